// *** design/spkdg_pkg.sv ***
package spkdg_pkg;

   // ==========================================================
   // channel count and timing
   // ==========================================================
   localparam int  NUM_CH          = 4;
   localparam int  CLK_HZ          = 25000000;
   localparam int  RECHECK_US      = 1000;
   localparam int  DIAG_CYCLE_MS   = 100;
   localparam int  PULSE_MS        = 100;
   localparam int  RECHECK_CYCLES  = (CLK_HZ / 1000000) * RECHECK_US;
   localparam int  DIAG_CYCLES     = (CLK_HZ / 1000) * DIAG_CYCLE_MS;
   localparam int  PULSE_CYCLES    = (CLK_HZ / 1000) * PULSE_MS;
   localparam int  AC_MIN_PULSES   = 3;
   localparam int  CNT_W           = 24;

   // ==========================================================
   // analog sense flags from one channel
   // ==========================================================
   typedef struct packed {
      logic short_gnd_src;
      logic short_gnd_sink;
      logic short_vs;
      logic short_load_pa;
      logic short_load_ld;
      logic open_load_pa;
      logic open_load_ld;
      logic offset_high;
      logic cur_above_hi;
      logic overload;
   } spkdg_sense_type;

   // ==========================================================
   // per-channel reported fault set
   // ==========================================================
   typedef struct packed {
      logic open_tweeter;
      logic permanent;
      logic short_load;
      logic open_or_offset;
      logic short_vs;
      logic short_gnd;
   } spkdg_fault_type;

   localparam spkdg_fault_type FAULT_NONE = '0;

   // ==========================================================
   // channel sequencer states
   // ==========================================================
   typedef enum logic [2:0] {
      CH_IDLE,
      CH_PULSE,
      CH_ACTIVE,
      CH_RECHECK,
      CH_DIAG,
      CH_RESTART,
      CH_HOLD
   } spkdg_state_type;

endpackage : spkdg_pkg

// *** design/spkdg_chan.sv ***
`timescale 1ns/1ps
`default_nettype none

module spkdg_chan
   import spkdg_pkg::*;
#(
   parameter int RECHECK_N = RECHECK_CYCLES,
   parameter int DIAG_N    = DIAG_CYCLES,
   parameter int PULSE_N   = PULSE_CYCLES
)(
   // clock, reset, enable
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            ce,
   // control
   input  wire logic            diag_en,
   input  wire logic            start_pulse,
   input  wire logic            line_drv,
   input  wire logic            rearm,
   input  wire logic            ofs_open,
   input  wire logic            ac_open,
   // synchronised sense
   input  wire spkdg_sense_type sense,
   // results
   output spkdg_fault_type      fault,
   output logic                 shut_down,
   output logic                 cycle_done,
   output logic                 ofs_flag,
   output logic                 ac_open_tw
);

   spkdg_state_type   state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg;
   spkdg_fault_type   fault_reg;
   logic              done_reg;
   logic              ofs_ok_reg;
   logic              ac_ok_reg;
   logic [1:0]        pulses_reg;
   logic              prot_seen_reg;
   logic              hi_d_reg;

   // ==========================================================
   // fault classification
   // ==========================================================
   wire logic sgnd_any  = sense.short_gnd_src | sense.short_gnd_sink;
   wire logic sl_use    = line_drv ? sense.short_load_ld : sense.short_load_pa;
   wire logic ol_use    = line_drv ? sense.open_load_ld : sense.open_load_pa;
   wire logic both_src  = sense.short_gnd_src & sense.short_vs;
   wire logic rep_vs    = sense.short_vs;
   wire logic rep_gnd   = sense.short_gnd_src | (sense.short_gnd_sink & ~sense.short_vs
                          & ~ol_use);
   wire logic rep_sl    = sl_use & ~sgnd_any & ~sense.short_vs;
   wire logic rep_ol    = ol_use & ~sense.short_vs & ~sense.short_gnd_src;
   wire logic any_short = sgnd_any | sense.short_vs | sl_use;
   wire logic cnt_zero  = (cnt_reg == '0);
   wire logic pulse_end = (state_reg == CH_PULSE) && cnt_zero;
   wire logic diag_end  = (state_reg == CH_DIAG) && cnt_zero;
   wire spkdg_fault_type turnon_f = '{open_tweeter: 1'b0, permanent: 1'b0,
                                      short_load: rep_sl, open_or_offset: rep_ol,
                                      short_vs: rep_vs | both_src, short_gnd: rep_gnd};
   // permanent diagnostics never report open load
   wire spkdg_fault_type perm_f   = '{open_tweeter: 1'b0, permanent: 1'b1,
                                      short_load: rep_sl, open_or_offset: 1'b0,
                                      short_vs: rep_vs, short_gnd: rep_gnd};

   // ==========================================================
   // state machine
   // ==========================================================
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         CH_IDLE:    if (start_pulse) state_next = CH_PULSE;
         CH_PULSE:   if (cnt_zero) state_next = CH_ACTIVE;
         CH_ACTIVE:  if (sense.overload) state_next = CH_RECHECK;
         CH_RECHECK: if (cnt_zero)
                        state_next = !sense.overload ? CH_ACTIVE
                                   : (diag_en ? CH_DIAG : CH_RESTART);
         CH_DIAG:    if (cnt_zero) state_next = CH_HOLD;
         CH_HOLD:    if (rearm) state_next = CH_RESTART;
         CH_RESTART: if (cnt_zero) state_next = CH_RECHECK;
      endcase
      if (start_pulse && state_reg != CH_PULSE)
         state_next = CH_PULSE;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg     <= CH_IDLE;
         cnt_reg       <= '0;
         fault_reg     <= FAULT_NONE;
         done_reg      <= 1'b0;
         ofs_ok_reg    <= 1'b0;
         ac_ok_reg     <= 1'b0;
         pulses_reg    <= '0;
         prot_seen_reg <= 1'b0;
         hi_d_reg      <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         hi_d_reg  <= sense.cur_above_hi;
         if (state_next != state_reg || (state_reg == CH_RESTART && cnt_zero))
            cnt_reg <= (state_next == CH_PULSE)   ? CNT_W'(PULSE_N - 1)
                     : (state_next == CH_DIAG)    ? CNT_W'(DIAG_N - 1)
                     : CNT_W'(RECHECK_N - 1);
         else if (!cnt_zero)
            cnt_reg <= cnt_reg - 1'b1;
         if (pulse_end)
         begin
            fault_reg <= turnon_f;
            done_reg  <= 1'b1;
         end
         else if (diag_end)
         begin
            fault_reg <= perm_f;
            done_reg  <= 1'b1;
         end
         else if (state_reg == CH_ACTIVE && any_short && !fault_reg.permanent)
            fault_reg <= perm_f;
         if (rearm && !pulse_end && !diag_end)
            done_reg <= 1'b0;
         // offset window: set at open, kept only while persistent
         if (ofs_open)
            ofs_ok_reg <= 1'b1;
         else if (!sense.offset_high)
            ofs_ok_reg <= 1'b0;
         if (ac_open || rearm)
         begin
            ac_ok_reg     <= 1'b0;
            pulses_reg    <= '0;
            prot_seen_reg <= sense.overload;
         end
         else
         begin
            if (sense.overload)
               prot_seen_reg <= 1'b1;
            if (sense.cur_above_hi && !hi_d_reg && pulses_reg != 2'(AC_MIN_PULSES))
               pulses_reg <= pulses_reg + 1'b1;
            if (pulses_reg == 2'(AC_MIN_PULSES))
               ac_ok_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign fault      = fault_reg;
   assign shut_down  = (state_reg == CH_RECHECK) || (state_reg == CH_DIAG)
                    || (state_reg == CH_HOLD) || (state_reg == CH_RESTART);
   assign cycle_done = done_reg;
   assign ofs_flag   = ofs_ok_reg & sense.offset_high & ~prot_seen_reg;
   assign ac_open_tw = ~ac_ok_reg & ~prot_seen_reg;

   // ==========================================================
   // checks
   // ==========================================================
   sequence recheck_pass_s;
      state_reg == CH_RECHECK && cnt_zero && !sense.overload;
   endsequence

   recheck_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && !start_pulse) and recheck_pass_s |=> state_reg == CH_ACTIVE)
      else $error("recheck without overload did not resume");

   recheck_diag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state_reg == CH_RECHECK && cnt_zero && sense.overload && diag_en
      && !start_pulse |=> state_reg == CH_DIAG && cnt_reg == CNT_W'(DIAG_N - 1))
      else $error("diagnostic cycle not started with full length");

   hold_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == CH_HOLD && !rearm && !start_pulse |=> state_reg == CH_HOLD)
      else $error("next cycle started without a read");

   perm_open_a: assert property (@(posedge clk) disable iff (!rst_n)
      fault_reg.permanent |-> !fault_reg.open_or_offset)
      else $error("open load reported in permanent mode");

   vs_dom_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && pulse_end && sense.short_vs && !sense.short_gnd_src
      |=> fault_reg.short_vs && !fault_reg.short_gnd)
      else $error("supply short did not dominate");

endmodule : spkdg_chan

`default_nettype wire

// *** design/spkdg_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module spkdg_top
   import spkdg_pkg::*;
#(
   parameter int RECHECK_N = RECHECK_CYCLES,
   parameter int DIAG_N    = DIAG_CYCLES,
   parameter int PULSE_N   = PULSE_CYCLES
)(
   // clock, reset and enable
   input  wire logic                     MCLK,
   input  wire logic                     NRST,
   input  wire logic                     CE,
   // decoded instruction bits
   input  wire logic                     DIAG_EN,
   input  wire logic                     OFS_EN,
   input  wire logic                     STANDBY_OFF,
   input  wire logic                     LINE_DRV_SEL,
   input  wire logic                     AC_EN,
   input  wire logic [NUM_CH-1:0]        LOW_GAIN,
   input  wire logic                     HOST_READ,
   // analog comparator pins
   input  wire spkdg_sense_type [NUM_CH-1:0] SENSE,
   // results
   output spkdg_fault_type [NUM_CH-1:0]  FAULT_REPORT,
   output logic [NUM_CH-1:0]             OFFSET_REPORT,
   output logic [NUM_CH-1:0]             CHAN_SHUTDOWN,
   output logic                          CYCLE_DONE,
   output logic                          POWER_STAGE_ON
);

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   spkdg_sense_type [NUM_CH-1:0] sense_s1_reg, sense_reg;
   logic stby_reg, ofs_en_reg, ac_en_reg;
   logic pulse_busy_reg;

   wire logic stby_rise = STANDBY_OFF & ~stby_reg;
   wire logic start_pulse = stby_rise & DIAG_EN;
   wire logic ofs_open = HOST_READ | (OFS_EN & ~ofs_en_reg);
   wire logic ac_open  = AC_EN & ~ac_en_reg;

   spkdg_fault_type [NUM_CH-1:0] fault_w;
   logic [NUM_CH-1:0]            shut_w, done_w, ofs_w, actw_w;
   spkdg_fault_type [NUM_CH-1:0] snap_reg;
   logic [NUM_CH-1:0]            ofs_snap_reg;
   logic [NUM_CH-1:0]            shut_reg;
   logic                         done_reg;
   logic                         stage_reg;

   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         sense_s1_reg <= '0;
         sense_reg    <= '0;
      end
      else if (CE)
      begin
         sense_s1_reg <= SENSE;
         sense_reg    <= sense_s1_reg;
      end
   end

   // ==========================================================
   // channels
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         spkdg_chan #(
            .RECHECK_N (RECHECK_N),
            .DIAG_N    (DIAG_N),
            .PULSE_N   (PULSE_N)
         ) u_chan (
            .clk         (MCLK),
            .rst_n       (NRST),
            .ce          (CE),
            .diag_en     (DIAG_EN),
            .start_pulse (start_pulse),
            .line_drv    (LOW_GAIN[g] & LINE_DRV_SEL),
            .rearm       (HOST_READ),
            .ofs_open    (ofs_open),
            .ac_open     (ac_open),
            .sense       (sense_reg[g]),
            .fault       (fault_w[g]),
            .shut_down   (shut_w[g]),
            .cycle_done  (done_w[g]),
            .ofs_flag    (ofs_w[g]),
            .ac_open_tw  (actw_w[g])
         );
      end
   endgenerate

   // ==========================================================
   // read snapshot: host sees previous cycle
   // ==========================================================
   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         stby_reg       <= 1'b0;
         ofs_en_reg     <= 1'b0;
         ac_en_reg      <= 1'b0;
         pulse_busy_reg <= 1'b0;
         snap_reg       <= '0;
         ofs_snap_reg   <= '0;
         shut_reg       <= '0;
         done_reg       <= 1'b0;
         stage_reg      <= 1'b0;
      end
      else if (CE)
      begin
         stby_reg   <= STANDBY_OFF;
         ofs_en_reg <= OFS_EN;
         ac_en_reg  <= AC_EN;
         shut_reg   <= shut_w;
         if (start_pulse)
            pulse_busy_reg <= 1'b1;
         else if (pulse_busy_reg && done_w != '0)
            pulse_busy_reg <= 1'b0;
         stage_reg <= STANDBY_OFF & ~start_pulse
                    & ~(pulse_busy_reg && done_w == '0);
         if (HOST_READ)
         begin
            for (int i = 0; i < NUM_CH; i++)
            begin
               snap_reg[i] <= fault_w[i];
               snap_reg[i].open_tweeter <= AC_EN & actw_w[i];
            end
            ofs_snap_reg <= OFS_EN ? ofs_w : '0;
            done_reg     <= &done_w;
         end
      end
   end

   assign FAULT_REPORT   = snap_reg;
   assign OFFSET_REPORT  = ofs_snap_reg;
   assign CHAN_SHUTDOWN  = shut_reg;
   assign CYCLE_DONE     = done_reg;
   assign POWER_STAGE_ON = stage_reg;

   // ==========================================================
   // checks
   // ==========================================================
   stage_hiz_a: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && start_pulse |=> !POWER_STAGE_ON)
      else $error("power stage left standby during pulse");

   snap_read_a: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && !HOST_READ |=> $stable(FAULT_REPORT))
      else $error("report changed without a read");

   ofs_gate_a: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && HOST_READ && !OFS_EN |=> OFFSET_REPORT == '0)
      else $error("offset reported while disabled");

endmodule : spkdg_top

`default_nettype wire

// *** test/spkdg_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// speaker and tone current model
// ==========================================================
module spkdg_load_model
   import spkdg_pkg::*;
(
   // clock
   input  wire logic                         clk,
   // fault setup and tone
   input  wire spkdg_sense_type [NUM_CH-1:0] cfg,
   input  wire logic                         tone_go,
   input  wire logic [NUM_CH-1:0][3:0]       tone_n,
   // comparator pins
   output var  spkdg_sense_type [NUM_CH-1:0] sense
);
   logic [NUM_CH-1:0][3:0] left_reg = '0;
   logic [2:0]             ph_reg   = 3'h0;
   logic                   go_reg   = 1'b0;

   // tone pulses, four cycles high in eight
   always @(posedge clk)
   begin
      go_reg <= tone_go;
      ph_reg <= ph_reg + 3'h1;
      if (tone_go && !go_reg)
      begin
         left_reg <= tone_n;
         ph_reg   <= 3'h0;
      end
      else if (ph_reg == 3'h7)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (left_reg[i] != 4'h0)
               left_reg[i] <= left_reg[i] - 4'h1;
         end
      end
   end

   // no current above threshold outside the tone
   always_comb
   begin
      sense = cfg;
      for (int i = 0; i < NUM_CH; i++)
         sense[i].cur_above_hi = (left_reg[i] != 4'h0) && ph_reg[2];
   end
endmodule : spkdg_load_model

`default_nettype wire

// *** test/spkdg_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module spkdg_top_tb
   import spkdg_pkg::*;
;
   localparam int RN = 8;
   localparam int DN = 20;
   localparam int PN = 20;

   logic                         mclk;
   logic                         nrst;
   logic                         ce;
   logic                         diag_en;
   logic                         ofs_en;
   logic                         stb_off;
   logic                         ld_sel;
   logic                         ac_en;
   logic [NUM_CH-1:0]            low_gain;
   logic                         host_read;
   spkdg_sense_type [NUM_CH-1:0] cfg;
   spkdg_sense_type [NUM_CH-1:0] sense;
   logic [NUM_CH-1:0][3:0]       tone_n;
   spkdg_fault_type [NUM_CH-1:0] fault_rep;
   logic [NUM_CH-1:0]            ofs_rep;
   logic [NUM_CH-1:0]            shut;
   logic                         done;
   logic                         pso;
   int                           miscompares = 0;
   int                           n_compared  = 0;

   // ==========================================================
   // design and far side
   // ==========================================================
   spkdg_top #(.RECHECK_N(RN), .DIAG_N(DN), .PULSE_N(PN)) spkdg_top_i (
      .MCLK(mclk), .NRST(nrst), .CE(ce), .DIAG_EN(diag_en), .OFS_EN(ofs_en),
      .STANDBY_OFF(stb_off), .LINE_DRV_SEL(ld_sel), .AC_EN(ac_en),
      .LOW_GAIN(low_gain), .HOST_READ(host_read), .SENSE(sense),
      .FAULT_REPORT(fault_rep), .OFFSET_REPORT(ofs_rep),
      .CHAN_SHUTDOWN(shut), .CYCLE_DONE(done), .POWER_STAGE_ON(pso));

   spkdg_load_model spkdg_load_model_i (
      .clk(mclk), .cfg(cfg), .tone_go(ac_en), .tone_n(tone_n), .sense(sense));

   // ==========================================================
   // tasks
   // ==========================================================
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task rd;
      host_read = 1'b1;
      cyc(1);
      host_read = 1'b0;
      cyc(2);
   endtask : rd

   task pulse;
      stb_off = 1'b0;
      cyc(4);
      diag_en = 1'b1;
      stb_off = 1'b1;
      cyc(3);
      chk(pso, 1'b0);
      cyc(PN - 4);
      // faults leave before the active phase sees them
      cfg = '0;
      cyc(14);
      chk(pso, 1'b1);
      rd;
      chk(done, 1'b1);
   endtask : pulse

   task finish_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // ==========================================================
   // clock and watchdog
   // ==========================================================
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial
   begin
      #(40 * 5000);
      miscompares++;
      finish_test;
   end

   // ==========================================================
   // tests
   // ==========================================================
   initial
   begin
      {nrst, diag_en, ofs_en, stb_off, ld_sel, ac_en, host_read} = '0;
      low_gain = 4'h0;
      ce       = 1'b1;
      cfg      = '0;
      tone_n   = '0;
      cyc(4);
      nrst = 1'b1;
      cyc(2);
      chk(fault_rep, 24'h000000);
      chk({shut, pso}, 5'h00);
      // turn-on with one single and three double faults
      cfg[0].short_gnd_src  = 1'b1;
      cfg[1].short_gnd_src  = 1'b1;
      cfg[1].short_vs       = 1'b1;
      cfg[2].short_gnd_sink = 1'b1;
      cfg[2].open_load_pa   = 1'b1;
      cfg[3].short_vs       = 1'b1;
      cfg[3].open_load_pa   = 1'b1;
      pulse;
      chk(fault_rep[0], 6'h01);
      chk(fault_rep[1], 6'h03);
      chk(fault_rep[2], 6'h04);
      chk(fault_rep[3], 6'h02);
      // line-driver thresholds only with low gain and select
      low_gain = 4'ha;
      ld_sel   = 1'b1;
      for (int i = 0; i < NUM_CH; i++)
         cfg[i].open_load_ld = 1'b1;
      pulse;
      chk(fault_rep, 24'h100100);
      // brief overload clears at recheck
      cfg[0].overload = 1'b1;
      cyc(3);
      cfg[0].overload = 1'b0;
      cyc(2);
      chk(shut[0], 1'b1);
      cyc(RN + 10);
      chk(shut[0], 1'b0);
      // persistent overload runs a diagnostic cycle
      cfg[2].overload      = 1'b1;
      cfg[2].short_gnd_src = 1'b1;
      cfg[2].open_load_pa  = 1'b1;
      cyc(RN + DN + 20);
      chk(shut, 4'h4);
      cyc(30);
      chk(shut[2], 1'b1);
      // read while frozen is ignored
      ce = 1'b0;
      rd;
      chk(shut[2], 1'b1);
      chk(fault_rep[2], 6'h00);
      ce = 1'b1;
      cfg = '0;
      cyc(4);
      rd;
      chk(fault_rep[2], 6'h11);
      chk(fault_rep[1], 6'h04);
      cyc(3 * RN + 20);
      chk(shut, 4'h0);
      // restart mode with diagnostics off
      diag_en         = 1'b0;
      cfg[3].overload = 1'b1;
      cyc(6);
      chk(shut, 4'h8);
      cyc(2 * RN);
      chk(shut[3], 1'b1);
      cfg[3].overload = 1'b0;
      cyc(2 * RN + 10);
      chk(shut, 4'h0);
      diag_en = 1'b1;
      // offset windows
      cfg[0].offset_high = 1'b1;
      cfg[1].offset_high = 1'b1;
      cyc(4);
      ofs_en = 1'b1;
      cyc(10);
      cfg[0].offset_high = 1'b0;
      cfg[2].offset_high = 1'b1;
      cfg[3].offset_high = 1'b1;
      cyc(10);
      rd;
      chk(ofs_rep, 4'h2);
      cyc(5);
      cfg[2].overload = 1'b1;
      cyc(3);
      cfg[2].overload = 1'b0;
      cyc(RN + 20);
      rd;
      chk(ofs_rep, 4'ha);
      ofs_en = 1'b0;
      cfg    = '0;
      // tone current pulses per channel
      tone_n = {4'h0, 4'h5, 4'h2, 4'h3};
      ac_en  = 1'b1;
      cyc(60);
      rd;
      for (int i = 0; i < NUM_CH; i++)
         chk(fault_rep[i].open_tweeter, (i == 1 || i == 3));
      finish_test;
   end
endmodule : spkdg_top_tb

`default_nettype wire
